/* hdl/srhp_top.sv */
`timescale 1ns/10ps
module srhp_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe_o,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic [7:0] status_mirror_i,
  input wire logic [15:0] chan0_result_i,
  input wire logic [15:0] chan1_result_i,
  input wire logic [31:0] chan0_timestamp_i,
  input wire logic [1:0] basic_status_i,
  input wire logic [1:0] detail_status_i
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] source_id_cfg_0_reg; // id field and source-0 wrap
  logic [7:0] source_id_cfg_1_reg; // id field and source-1 wrap
  logic [7:0] ptr_reg; // i2c register pointer
  logic [31:0] tx_word_reg; // response for the next frame

  // register read decode, shared by both serial ports
  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input logic [7:0] cfg0,
    input logic [7:0] cfg1
  );
    logic [7:0] val;
    val = 8'h00; // unmapped addresses read as zero
    unique case (addr)
      srhp_pkg::ADDR_SRC_CFG0: val = cfg0;
      srhp_pkg::ADDR_SRC_CFG1: val = cfg1;
      srhp_pkg::ADDR_STATUS_MIRROR: val = status_mirror_i;
      srhp_pkg::ADDR_CHAN0_LOW: val = chan0_result_i[7:0];
      srhp_pkg::ADDR_CHAN0_HIGH: val = chan0_result_i[15:8];
      srhp_pkg::ADDR_CHAN1_LOW: val = chan1_result_i[7:0];
      srhp_pkg::ADDR_CHAN1_HIGH: val = chan1_result_i[15:8];
      srhp_pkg::ADDR_TS0_BYTE0: val = chan0_timestamp_i[7:0];
      srhp_pkg::ADDR_TS0_BYTE1: val = chan0_timestamp_i[15:8];
      srhp_pkg::ADDR_TS0_BYTE2: val = chan0_timestamp_i[23:16];
      srhp_pkg::ADDR_TS0_BYTE3: val = chan0_timestamp_i[31:24];
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // ----------------------------------------
  // i2c client
  // ----------------------------------------
  logic [7:0] i2c_byte; // last byte received
  logic i2c_addr_wr; // pulse: register address arrived
  logic i2c_data_wr; // pulse: data byte arrived
  logic i2c_rd_adv; // pulse: read byte taken
  logic [7:0] i2c_rd_byte; // byte at the pointer

  assign i2c_rd_byte = reg_read(ptr_reg, source_id_cfg_0_reg, source_id_cfg_1_reg);

  // scl is input only: the client has no way to stretch it
  srhp_i2c_client u_i2c (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_i(i2c_scl_i),
    .sda_i(i2c_sda_i),
    .rd_byte_i(i2c_rd_byte),
    .sda_oe_o(i2c_sda_oe_o),
    .byte_o(i2c_byte),
    .addr_wr_o(i2c_addr_wr),
    .data_wr_o(i2c_data_wr),
    .rd_adv_o(i2c_rd_adv)
  );

  // open drain: only ever pulls low
  assign i2c_sda_o = 1'b0;

  // ----------------------------------------
  // read pointer wrap-around
  // ----------------------------------------
  logic wrap0, wrap1; // wrap enables
  logic [7:0] wrap_top; // last address of the window
  logic wrap_hit; // pointer sits on the window's end
  logic [7:0] ptr_read_next; // pointer after a read byte
  logic [7:0] ptr_plain_next; // pointer after a written byte

  assign wrap0 = source_id_cfg_0_reg[srhp_pkg::WRAP_EN_BIT];
  assign wrap1 = source_id_cfg_1_reg[srhp_pkg::WRAP_EN_BIT];
  assign wrap_top = (wrap0 && wrap1) ? srhp_pkg::ADDR_TS0_BYTE3 :
    wrap1 ? srhp_pkg::ADDR_CHAN1_HIGH :
    srhp_pkg::ADDR_CHAN0_HIGH;
  assign wrap_hit = (wrap0 || wrap1) && (ptr_reg == wrap_top);
  assign ptr_plain_next = ptr_reg + 8'h01; // rolls ff to 00
  assign ptr_read_next = wrap_hit ? srhp_pkg::ADDR_STATUS_MIRROR : ptr_plain_next;

  // pointer follows every register byte that crosses the bus; device address bytes leave it alone
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= 8'h00;
    end else if (i2c_addr_wr) begin
      ptr_reg <= i2c_byte;
    end else if (i2c_data_wr) begin
      ptr_reg <= ptr_plain_next;
    end else if (i2c_rd_adv) begin
      ptr_reg <= ptr_read_next;
    end
  end

  // ----------------------------------------
  // spi link, runs on the host's sclk
  // ----------------------------------------
  logic [31:0] rx_word; // last frame received
  logic [5:0] rx_cnt; // edges counted in that frame

  srhp_spi_link u_spi (
    .sclk_i(spi_sclk_i),
    .rst_i(rst_i),
    .cs_n_i(spi_cs_n_i),
    .mosi_i(spi_mosi_i),
    .tx_word_i(tx_word_reg),
    .rx_word_o(rx_word),
    .bit_cnt_o(rx_cnt),
    .miso_o(spi_miso_o),
    .miso_oe_o(spi_miso_oe_o)
  );

  // ----------------------------------------
  // chip select crossing
  // ----------------------------------------
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg; // two flops plus edge
  logic frame_end; // one pulse per deselect

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= spi_cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  // sclk is stopped once chip select is high, so the link's word and
  // count are frozen by the time this edge is seen two flops later
  assign frame_end = cs_sync_reg & ~cs_prev_reg;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  srhp_pkg::srhp_frame_t frame; // received frame by field
  logic len_ok, is_sens, is_wr, is_rd, fixed_ok, accept;
  logic [2:0] src_req; // requested source_identifier
  logic hit0, hit1; // channel whose id matches

  localparam int SRC_ID_TOP = srhp_pkg::SRC_ID_W - 1;

  assign frame = rx_word;
  assign len_ok = rx_cnt == srhp_pkg::FRAME_LEN;
  assign is_sens = frame.code[0];
  assign is_wr = frame.code == srhp_pkg::CMD_WRITE;
  assign is_rd = frame.code == srhp_pkg::CMD_READ;
  // sensor frames carry 20 fixed zeros, register frames four
  assign fixed_ok = is_sens ? ({frame.fixed, frame.addr, frame.data} == 20'h00000) :
    (frame.fixed == 4'h0);
  // code 0 and the reserved even codes fall through to error
  assign accept = len_ok && fixed_ok && (is_sens || is_wr || is_rd);
  assign src_req = frame.code[3:1];
  assign hit0 = source_id_cfg_0_reg[SRC_ID_TOP:0] == src_req;
  assign hit1 = source_id_cfg_1_reg[SRC_ID_TOP:0] == src_req;

  // ----------------------------------------
  // response words
  // ----------------------------------------
  logic [7:0] rd_hi, rd_lo; // register pair of the word address
  logic [31:0] resp_reg_word; // register read or write reply
  srhp_pkg::srhp_sens_resp_t resp_sens; // sensor reply
  logic [31:0] resp_err; // error reply, no data
  logic [31:0] resp_next; // reply chosen for the next frame

  // the pair is read as it stands at deselect, before any write
  assign rd_hi = reg_read({frame.addr[7:1], 1'b1}, source_id_cfg_0_reg, source_id_cfg_1_reg);
  assign rd_lo = reg_read({frame.addr[7:1], 1'b0}, source_id_cfg_0_reg, source_id_cfg_1_reg);
  assign resp_reg_word = {frame.code, basic_status_i, 2'h0, rd_hi, rd_lo, srhp_pkg::CRC_FILL};

  always_comb begin
    resp_sens.code = frame.code;
    resp_sens.basic = basic_status_i;
    resp_sens.value = hit0 ? chan0_result_i[srhp_pkg::SENS_HI:srhp_pkg::SENS_LO] :
      chan1_result_i[srhp_pkg::SENS_HI:srhp_pkg::SENS_LO];
    resp_sens.extra = 4'h0;
    resp_sens.detail = detail_status_i;
    resp_sens.crc = srhp_pkg::CRC_FILL;
  end

  // error code zero is kept for replies only
  // sixteen unused zeros span bits 25:10
  assign resp_err = {srhp_pkg::CMD_ERROR, srhp_pkg::ERR_STATUS, 16'h0000,
    detail_status_i, srhp_pkg::CRC_FILL};

  assign resp_next = !accept ? resp_err :
    !is_sens ? resp_reg_word :
    (hit0 || hit1) ? resp_sens : resp_err;

  // ----------------------------------------
  // execution at deselect
  // ----------------------------------------
  logic spi_wr; // accepted spi register write
  logic [7:0] wr_addr, wr_data; // merged write port
  logic wr_en;

  assign spi_wr = frame_end && accept && is_wr;
  // spi wins if both ports write in one cycle; hosts are not
  // expected to use both ports at once
  assign wr_en = spi_wr || i2c_data_wr;
  assign wr_addr = spi_wr ? frame.addr : ptr_reg;
  assign wr_data = spi_wr ? frame.data : i2c_byte;

  // configuration writes; other addresses are read only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_id_cfg_0_reg <= srhp_pkg::SRC_CFG_RESET;
      source_id_cfg_1_reg <= srhp_pkg::SRC_CFG_RESET;
    end else if (wr_en && wr_addr == srhp_pkg::ADDR_SRC_CFG0) begin
      source_id_cfg_0_reg <= wr_data;
    end else if (wr_en && wr_addr == srhp_pkg::ADDR_SRC_CFG1) begin
      source_id_cfg_1_reg <= wr_data;
    end
  end

  // the reply is latched while chip select is high and only goes out
  // in the following frame; the host must leave select high long
  // enough for this update to land
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_word_reg <= 32'h0000_0000;
    end else if (frame_end) begin
      tx_word_reg <= resp_next;
    end
  end
endmodule

/* shared/srhp_pkg.sv */
package srhp_pkg;
  // ----------------------------------------
  // spi framing
  // ----------------------------------------
  localparam logic [5:0] FRAME_LEN = 6'h20; // bits per frame
  localparam logic [5:0] FRAME_TOP = 6'h1f; // index of the msb
  localparam logic [3:0] CMD_ERROR = 4'h0; // never a request
  localparam logic [3:0] CMD_WRITE = 4'h8; // register write
  localparam logic [3:0] CMD_READ = 4'hc; // register read
  localparam logic [1:0] ERR_STATUS = 2'h3; // basic status of errors
  localparam logic [7:0] CRC_FILL = 8'h00; // crc is produced elsewhere
  localparam int SENS_HI = 15; // top of the 12-bit reported slice
  localparam int SENS_LO = 4; // bottom of that slice

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_SRC_CFG0 = 8'h1a;
  localparam logic [7:0] ADDR_SRC_CFG1 = 8'h1b;
  localparam logic [7:0] ADDR_STATUS_MIRROR = 8'h61;
  localparam logic [7:0] ADDR_CHAN0_LOW = 8'h62;
  localparam logic [7:0] ADDR_CHAN0_HIGH = 8'h63;
  localparam logic [7:0] ADDR_CHAN1_LOW = 8'h64;
  localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h65;
  localparam logic [7:0] ADDR_TS0_BYTE0 = 8'h66;
  localparam logic [7:0] ADDR_TS0_BYTE1 = 8'h67;
  localparam logic [7:0] ADDR_TS0_BYTE2 = 8'h68;
  localparam logic [7:0] ADDR_TS0_BYTE3 = 8'h69;
  localparam logic [7:0] SRC_CFG_RESET = 8'h00;
  localparam int WRAP_EN_BIT = 7; // wrap_enable_srcN
  localparam int SRC_ID_W = 3; // source_id_field in bits 2:0

  // ----------------------------------------
  // i2c client
  // ----------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK_A = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_ACK_W = 3'b100,
    I2C_READ = 3'b101,
    I2C_ACK_R = 3'b110
  } srhp_i2c_state_t;

  // ----------------------------------------
  // frame layouts
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] code; // command code
    logic [3:0] fixed; // must be zero
    logic [7:0] addr; // reg_address_field
    logic [7:0] data; // write data
    logic [7:0] crc;
  } srhp_frame_t;

  typedef struct packed {
    logic [3:0] code;
    logic [1:0] basic;
    logic [11:0] value;
    logic [3:0] extra; // optional resolution, zero here
    logic [1:0] detail;
    logic [7:0] crc;
  } srhp_sens_resp_t;
endpackage

/* hdl/srhp_spi_link.sv */
`timescale 1ns/10ps
module srhp_spi_link (
  input wire logic sclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [31:0] tx_word_i,
  output logic [31:0] rx_word_o,
  output logic [5:0] bit_cnt_o,
  output logic miso_o,
  output logic miso_oe_o
);
  // ----------------------------------------
  // link-side state, clocked by the host's sclk
  // ----------------------------------------
  logic frame_rst; // chip select idle or block reset
  logic new_frame_reg; // no rising edge seen yet in this frame
  logic [31:0] rx_reg; // incoming shift register
  logic [5:0] cnt_reg; // rising edges in frame, saturating
  logic miso_reg; // bit driven after a falling edge
  logic started_reg; // a falling edge has been seen in this frame
  logic [4:0] tx_idx; // next bit to drive

  assign frame_rst = rst_i | cs_n_i;
  assign tx_idx = 5'(srhp_pkg::FRAME_TOP - cnt_reg);

  // marks the gap before the first rising edge of a frame
  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      new_frame_reg <= 1'b1;
    end else begin
      new_frame_reg <= 1'b0;
    end
  end

  // sample mosi on the rising edge, msb first; deselected edges do nothing
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
    end else if (!cs_n_i) begin
      rx_reg <= {rx_reg[30:0], mosi_i};
      if (new_frame_reg) begin
        cnt_reg <= 6'h01;
      end else if (cnt_reg <= srhp_pkg::FRAME_LEN) begin
        cnt_reg <= cnt_reg + 6'h01; // stops one past a full frame
      end
    end
  end

  // change miso on the falling edge; the word is held still by the
  // core side for the whole frame, so sampling it here is safe
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      miso_reg <= 1'b0;
    end else if (cnt_reg < srhp_pkg::FRAME_LEN) begin
      miso_reg <= tx_word_i[tx_idx];
    end
  end

  // the msb stands from select until the first falling edge, through the
  // first rising edge; switching at a rising edge would break the hold
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  assign miso_o = started_reg ? miso_reg : tx_word_i[31];
  assign miso_oe_o = ~cs_n_i;
  assign rx_word_o = rx_reg;
  assign bit_cnt_o = cnt_reg;
endmodule

/* hdl/srhp_i2c_client.sv */
`timescale 1ns/10ps
module srhp_i2c_client #(
  parameter logic [6:0] CLIENT_ADDR = 7'h2a // arbitrary bus address
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] rd_byte_i,
  output logic sda_oe_o,
  output logic [7:0] byte_o,
  output logic addr_wr_o,
  output logic data_wr_o,
  output logic rd_adv_o
);
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
    end else begin
      {scl_meta, scl_sync, scl_prev} <= {scl_i, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {sda_i, sda_meta, sda_sync};
    end
  end

  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // ----------------------------------------
  // byte engine; scl is never held, all work fits the ack pulse
  // ----------------------------------------
  srhp_pkg::srhp_i2c_state_t state_reg;
  logic [3:0] cnt_reg; // bits of the current byte
  logic [7:0] shift_reg; // byte in or out
  logic rw_reg; // direction bit of the address byte
  logic first_reg; // next written byte is the register address
  logic oe_reg, addr_wr_reg, data_wr_reg, adv_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= srhp_pkg::I2C_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b1;
      oe_reg <= 1'b0;
      addr_wr_reg <= 1'b0;
      data_wr_reg <= 1'b0;
      adv_reg <= 1'b0;
    end else begin
      addr_wr_reg <= 1'b0;
      data_wr_reg <= 1'b0;
      adv_reg <= 1'b0;
      if (start_det) begin // start or repeated_start
        state_reg <= srhp_pkg::I2C_ADDR;
        cnt_reg <= 4'h0;
        oe_reg <= 1'b0;
        first_reg <= 1'b1;
      end else if (stop_det) begin
        state_reg <= srhp_pkg::I2C_IDLE;
        oe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          srhp_pkg::I2C_IDLE: begin
            oe_reg <= 1'b0;
          end
          srhp_pkg::I2C_ADDR, srhp_pkg::I2C_WRITE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == srhp_pkg::BYTE_BITS) begin
              oe_reg <= 1'b1; // acknowledge
              if (state_reg == srhp_pkg::I2C_ADDR) begin
                if (shift_reg[7:1] == CLIENT_ADDR) begin
                  rw_reg <= shift_reg[0];
                  state_reg <= srhp_pkg::I2C_ACK_A;
                end else begin
                  oe_reg <= 1'b0; // not ours, stay off the bus
                  state_reg <= srhp_pkg::I2C_IDLE;
                end
              end else begin
                addr_wr_reg <= first_reg;
                data_wr_reg <= ~first_reg;
                first_reg <= 1'b0;
                state_reg <= srhp_pkg::I2C_ACK_W;
              end
            end
          end
          srhp_pkg::I2C_ACK_A: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg <= rd_byte_i;
                oe_reg <= ~rd_byte_i[7];
                adv_reg <= 1'b1;
                state_reg <= srhp_pkg::I2C_READ;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= srhp_pkg::I2C_WRITE;
              end
            end
          end
          srhp_pkg::I2C_ACK_W: begin
            if (scl_fall) begin
              oe_reg <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= srhp_pkg::I2C_WRITE;
            end
          end
          srhp_pkg::I2C_READ: begin
            if (scl_fall) begin
              if (cnt_reg == srhp_pkg::LAST_BIT) begin
                oe_reg <= 1'b0; // release for the host's ack
                state_reg <= srhp_pkg::I2C_ACK_R;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                oe_reg <= ~shift_reg[6];
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          srhp_pkg::I2C_ACK_R: begin
            if (scl_rise) begin // nack ends the read
              state_reg <= sda_sync ? srhp_pkg::I2C_IDLE : srhp_pkg::I2C_ACK_A;
            end
          end
          default: begin
            state_reg <= srhp_pkg::I2C_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_oe_o = oe_reg;
  assign byte_o = shift_reg;
  assign addr_wr_o = addr_wr_reg;
  assign data_wr_o = data_wr_reg;
  assign rd_adv_o = adv_reg;
endmodule

/* dv/srhp_assertions.sv */
`timescale 1ns/10ps
module srhp_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  input wire logic i2c_sda_o,
  input wire logic i2c_sda_oe_o,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o
);
  // ----
  // checks, one core domain
  // ----
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_oe_follows_cs: assert property (spi_miso_oe_o == !spi_cs_n_i)
    else $error("miso enable differs from chip select");
  a_miso_hold_high: assert property (!spi_cs_n_i && spi_sclk_i && $past(spi_sclk_i) |-> $stable(spi_miso_o))
    else $error("miso moved while sclk high");
  a_miso_fall_only: assert property ($changed(spi_miso_o) && !spi_cs_n_i && $past(!spi_cs_n_i) |-> !spi_sclk_i)
    else $error("miso moved outside sclk low");
  a_sda_scl_low: assert property ($changed(i2c_sda_oe_o) |-> !i2c_scl_i)
    else $error("sda drive changed while scl high");
  a_ack_holds: assert property ($rose(i2c_sda_oe_o) |-> i2c_sda_oe_o[*6])
    else $error("sda drive too short");
  a_start_not_driven: assert property ($fell(i2c_sda_i) && i2c_scl_i |-> !i2c_sda_oe_o)
    else $error("device drove sda at start");
  a_idle_after_stop: assert property ($rose(i2c_sda_i) && i2c_scl_i |=> !i2c_sda_oe_o[*4])
    else $error("sda driven after stop");
  a_sda_open_drain: assert property (i2c_sda_o == 1'b0)
    else $error("sda value not low");
endmodule
bind srhp_top srhp_assertions chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .i2c_scl_i(i2c_scl_i),
  .i2c_sda_i(i2c_sda_i), .i2c_sda_o(i2c_sda_o), .i2c_sda_oe_o(i2c_sda_oe_o), .spi_sclk_i(spi_sclk_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o));

/* dv/srhp_host_model.sv */
`timescale 1ns/10ps
module srhp_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // idle: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame, msb first; nb below 32 makes a short frame
  task automatic xfer(input logic [31:0] cmd, input int nb, output logic [31:0] rsp);
    rsp = 32'h0;
    cs_n_o = 1'b0;
    for (int i = 31; i > 31 - nb; i--) begin
      mosi_o = cmd[i];
      #15 sclk_o = 1'b1;
      rsp = {rsp[30:0], miso_i};
      #15 sclk_o = 1'b0;
    end
    #15 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line never shows a stale bit
    #40;
  endtask
endmodule

/* dv/srhp_top_tb_top.sv */
`timescale 1ns/10ps
module srhp_top_tb_top;
  // ----
  // pins and bookkeeping
  // ----
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl = 1'b1; // host i2c clock
  logic sda_h = 1'b1; // host sda, 1 = released
  logic sda_o, sda_oe, sclk, cs_n, mosi, miso, miso_oe;
  wire sda_w = sda_h & (sda_oe ? sda_o : 1'b1); // wired level of the open-drain line
  logic [8:0] rd; // last nine i2c bits
  logic [31:0] rsp;
  logic [7:0] b0, b1; // two i2c bytes read in a row
  logic [31:0] cyc = 32'h0; // also feeds the timestamp input
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [1:0] BS = 2'h1;
  localparam logic [1:0] DS = 2'h2;
  localparam logic [31:0] ERR = {srhp_pkg::CMD_ERROR, srhp_pkg::ERR_STATUS, 16'h0, DS, 8'h00};
  // rows: command, reply that the next frame carries
  logic [63:0] rows [15] = '{
    {32'h801a8200, 32'h84000000}, {32'h801b0500, 32'h84008200}, {32'hc01a0000, 32'hc4058200},
    {32'h50000000, 4'h5, BS, 12'hab5, 4'h0, DS, 8'h00}, {32'hb0000000, 4'hb, BS, 12'h123, 4'h0, DS, 8'h00},
    {32'hf0000000, ERR}, {32'h00000000, ERR}, {32'h20000000, ERR}, {32'h40000000, ERR},
    {32'h60000000, ERR}, {32'ha0000000, ERR}, {32'he0000000, ERR}, {32'h811a0000, ERR},
    {32'h10000100, ERR}, {32'hc01a0000, 32'hc4058200}};
  always #2 ref_clk_i = ~ref_clk_i;
  srhp_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .i2c_scl_i(scl), .i2c_sda_i(sda_w), .i2c_sda_o(sda_o),
    .i2c_sda_oe_o(sda_oe), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .status_mirror_i(8'h3c), .chan0_result_i(16'hab5c), .chan1_result_i(16'h1234),
    .chan0_timestamp_i(cyc), .basic_status_i(BS), .detail_status_i(DS));
  srhp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic w5();
    repeat (5) @(negedge ref_clk_i);
  endtask
  // one i2c bit; low and high phases of five core cycles
  task automatic ibit(input logic b);
    sda_h = b;
    w5();
    scl = 1'b1;
    w5();
    rd = {rd[7:0], sda_w};
    scl = 1'b0;
  endtask
  task automatic ibyte(input logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--) ibit(v[i]);
    ibit(ack);
  endtask
  // start and repeated start look alike
  task automatic istart();
    sda_h = 1'b1;
    w5();
    scl = 1'b1;
    w5();
    sda_h = 1'b0;
    w5();
    scl = 1'b0;
  endtask
  // stop: sda rises while scl is high
  task automatic istop();
    sda_h = 1'b0;
    w5();
    scl = 1'b1;
    w5();
    sda_h = 1'b1;
    w5();
  endtask
  // register read of two bytes from ra, host acks the first only
  task automatic iread2(input logic [7:0] ra, output logic [7:0] v0, output logic [7:0] v1);
    istart();
    ibyte(8'h54, 1'b1);
    ibyte(ra, 1'b1);
    istart();
    ibyte(8'h55, 1'b1);
    ibyte(8'hff, 1'b0);
    v0 = rd[8:1];
    ibyte(8'hff, 1'b1);
    v1 = rd[8:1];
    istop();
  endtask
  // hang guard
  always @(negedge ref_clk_i) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4e20) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(negedge ref_clk_i);
    chk({30'h0, sda_oe, miso_oe}, 32'h0, "outputs in reset");
    rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    foreach (rows[i]) begin
      host.xfer(rows[i][63:32], 32, rsp);
      if (i > 0) chk(rsp, rows[i-1][31:0], "spi reply");
    end
    host.xfer(32'h801a0000, 31, rsp);
    chk(rsp, {1'b0, rows[14][31:1]}, "short frame reply");
    host.xfer(32'hc01a0000, 32, rsp);
    chk(rsp, ERR, "discarded frame reply");
    host.xfer(32'h00000000, 32, rsp);
    chk(rsp, 32'hc4058200, "config kept");
    istart();
    ibyte(8'h54, 1'b1);
    chk({31'h0, rd[0]}, 32'h0, "write address ack");
    ibyte(8'h63, 1'b1);
    chk({31'h0, rd[0]}, 32'h0, "pointer ack");
    istart();
    ibyte(8'h55, 1'b1);
    chk({31'h0, rd[0]}, 32'h0, "read address ack");
    ibyte(8'hff, 1'b0);
    chk({24'h0, rd[8:1]}, 32'hab, "byte at 63h");
    ibyte(8'hff, 1'b1);
    chk({24'h0, rd[8:1]}, 32'h3c, "byte after wrap");
    istop();
    host.xfer(32'h801b8500, 32, rsp);
    chk(rsp, ERR, "zero code reply");
    iread2(8'h69, b0, b1);
    chk({24'h0, b0}, 32'h0, "timestamp byte 3");
    chk({24'h0, b1}, 32'h3c, "byte after both wraps");
    host.xfer(32'h801a0200, 32, rsp);
    chk(rsp, 32'h84058200, "write reply");
    iread2(8'h65, b0, b1);
    chk({24'h0, b0}, 32'h12, "byte at 65h");
    chk({24'h0, b1}, 32'h3c, "byte after source-1 wrap");
    wrap_up();
  end
endmodule
